// ### hdl/audio_codec_clock_selection.sv
// clock routing, glitch-free switching and clock output control
`timescale 1ns/100ps
`include "clock_select_cfg.svh"

module clock_glitch_free_switch
    import clock_select_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // sources and selection
    input wire logic [5:0] src_vec,
    input wire logic [2:0] sel,
    // switched clock
    output logic clk_out
);
    switch_state_t state_reg, state_next;
    logic [2:0] cur_reg, cur_next;
    logic out_next;
    wire logic old_level = src_vec[cur_reg];
    wire logic new_level = src_vec[sel];
    wire logic changed = (sel != cur_reg);

    // [R12] stop low, then start low
    always_comb begin
        state_next = state_reg;
        cur_next = cur_reg;
        out_next = old_level;
        unique case (state_reg)
            SW_RUN: begin
                if (changed && !old_level) begin
                    state_next = SW_ARM;
                    out_next = 1'b0;
                end else if (changed) begin
                    state_next = SW_DRAIN;
                end
            end
            SW_DRAIN: begin
                if (!old_level) begin
                    state_next = SW_ARM;
                    out_next = 1'b0;
                end
            end
            SW_ARM: begin
                out_next = 1'b0;
                if (!new_level) begin
                    cur_next = sel;
                    state_next = SW_RUN;
                end
            end
            // unused state code, park low and rerun
            default: begin
                out_next = 1'b0;
                state_next = SW_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= SW_RUN;
            cur_reg <= `SRC_XTAL;
            clk_out <= 1'b0;
        end else begin
            state_reg <= state_next;
            cur_reg <= cur_next;
            clk_out <= out_next;
        end
    end
endmodule : clock_glitch_free_switch

module audio_codec_clock_selection
    import clock_select_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register access from the control port
    input wire logic [6:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_wr_data,
    output logic [7:0] reg_rd_data,
    // clock sources from pins and PLLs
    input wire logic crystal_clock_input,
    input wire logic external_master_clock_input,
    input wire logic first_pll_rate_output,
    input wire logic second_pll_rate_output,
    input wire logic second_pll_alt_rate_output,
    input wire logic receiver_clock_512fs,
    input wire logic receiver_clock_256fs,
    // first PLL rate field from the PLL control logic
    input wire logic [1:0] first_pll_rate_select,
    // converter and internal clocks
    output logic dac_clock,
    output logic adc_clock,
    output logic first_internal_clock,
    output logic second_internal_clock,
    // PLL references
    output logic first_pll_reference,
    output logic second_pll_reference,
    // first PLL rate decode
    output logic first_pll_rate_valid,
    output logic [1:0] first_pll_rate_code,
    // receiver and system clock output control
    output logic receiver_power_down,
    output logic receiver_input_level_mode,
    output logic system_clock_out_a_enable,
    output logic system_clock_out_b_enable,
    output logic system_clock_out_c_enable
);
    localparam int NRAW = 7;

    function automatic logic [2:0] converter_source(input logic [2:0] code);
        // codes 110 and 111 fall back to the crystal
        converter_source = (code > `SRC_RX_256) ? `SRC_XTAL : code;
    endfunction : converter_source

    logic [7:0] conv_sel_reg, conv_sel_next;
    logic [7:0] int_sel_reg, int_sel_next;
    logic [7:0] ref_sel_reg, ref_sel_next;
    logic [7:0] out_en_reg, out_en_next;
    logic [7:0] rd_data_next;
    logic [NRAW-1:0] raw_in;
    logic [NRAW-1:0] sync1_reg, sync2_reg, sync3_reg;
    logic [NRAW-1:0] level_reg, level_next;
    logic fs1_half_reg, fs2_half_reg, fs3_half_reg;
    logic fs1_prev_reg, fs2_prev_reg, fs3_prev_reg;
    logic pll_a_reg, pll_a_next;
    logic pll_b_reg, pll_b_next;
    clock_sources_t srcs;
    reg_req_t req;

    assign req = '{addr: reg_addr, wr_en: reg_wr_en, rd_en: reg_rd_en,
                   wr_data: reg_wr_data};

    assign raw_in = {receiver_clock_256fs, receiver_clock_512fs,
                     second_pll_alt_rate_output, second_pll_rate_output,
                     first_pll_rate_output, external_master_clock_input,
                     crystal_clock_input};

    // three-stage capture, a change counts once stages two and three agree
    assign level_next = (sync2_reg & sync3_reg)
                        | (level_reg & (sync2_reg | sync3_reg));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            level_reg <= '0;
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            level_reg <= level_next;
        end
    end

    wire logic xtal_lvl = level_reg[0];
    wire logic mclk_lvl = level_reg[1];
    wire logic fs1_lvl = level_reg[2];
    wire logic fs2_lvl = level_reg[3];
    wire logic fs3_lvl = level_reg[4];

    // halved rates toggle on each rising edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fs1_prev_reg <= 1'b0;
            fs2_prev_reg <= 1'b0;
            fs3_prev_reg <= 1'b0;
            fs1_half_reg <= 1'b0;
            fs2_half_reg <= 1'b0;
            fs3_half_reg <= 1'b0;
        end else begin
            fs1_prev_reg <= fs1_lvl;
            fs2_prev_reg <= fs2_lvl;
            fs3_prev_reg <= fs3_lvl;
            fs1_half_reg <= fs1_half_reg ^ (fs1_lvl & ~fs1_prev_reg);
            fs2_half_reg <= fs2_half_reg ^ (fs2_lvl & ~fs2_prev_reg);
            fs3_half_reg <= fs3_half_reg ^ (fs3_lvl & ~fs3_prev_reg);
        end
    end

    wire logic [2:0] dac_sel = conv_sel_reg[`POS_DAC_SEL_HI:`POS_DAC_SEL_LO];
    wire logic [2:0] adc_sel = conv_sel_reg[`POS_ADC_SEL_HI:`POS_ADC_SEL_LO];
    wire logic [1:0] second_internal_clock_select_sel =
        conv_sel_reg[`POS_SECOND_INTERNAL_CLOCK_SELECT_SEL_HI:`POS_SECOND_INTERNAL_CLOCK_SELECT_SEL_LO];
    wire logic [1:0] first_internal_clock_select_sel =
        int_sel_reg[`POS_FIRST_INTERNAL_CLOCK_SELECT_SEL_HI:`POS_FIRST_INTERNAL_CLOCK_SELECT_SEL_LO];
    wire logic [1:0] pll2_tap =
        int_sel_reg[`POS_PLL2_TAP_HI:`POS_PLL2_TAP_LO];
    wire logic pll1_tap = int_sel_reg[`POS_PLL1_TAP];
    // [R11] reserved rate holds clock A low
    wire logic rate_ok = (first_pll_rate_select != `RATE_RESERVED);

    // [R5] internal PLL clock taps
    assign pll_a_next = rate_ok & (pll1_tap ? fs1_half_reg : fs1_lvl);
    assign pll_b_next = (pll2_tap == 2'h0) ? fs2_lvl :
                        (pll2_tap == 2'h1) ? fs2_half_reg :
                        (pll2_tap == 2'h2) ? fs3_lvl : fs3_half_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pll_a_reg <= 1'b0;
            pll_b_reg <= 1'b0;
        end else begin
            pll_a_reg <= pll_a_next;
            pll_b_reg <= pll_b_next;
        end
    end

    assign srcs = '{rx_256: level_reg[6], rx_512: level_reg[5],
                    pll_b: pll_b_reg, pll_a: pll_a_reg,
                    mclk: mclk_lvl, xtal: xtal_lvl};

    // [R1] DAC source mapping
    clock_glitch_free_switch dac_switch (
        .clk(clk),
        .rst_n(rst_n),
        .src_vec(srcs),
        .sel(converter_source(dac_sel)),
        .clk_out(dac_clock)
    );

    // [R2] ADC source mapping
    clock_glitch_free_switch adc_switch (
        .clk(clk),
        .rst_n(rst_n),
        .src_vec(srcs),
        .sel(converter_source(adc_sel)),
        .clk_out(adc_clock)
    );

    // [R4] first internal clock mapping
    clock_glitch_free_switch first_internal_clock_select_switch (
        .clk(clk),
        .rst_n(rst_n),
        .src_vec(srcs),
        .sel({1'b0, first_internal_clock_select_sel}),
        .clk_out(first_internal_clock)
    );

    // [R3] second internal clock mapping
    clock_glitch_free_switch second_internal_clock_select_switch (
        .clk(clk),
        .rst_n(rst_n),
        .src_vec(srcs),
        .sel({1'b0, second_internal_clock_select_sel}),
        .clk_out(second_internal_clock)
    );

    wire logic wr_conv = req.wr_en && (req.addr == `OFS_CONVERTER_CLOCK_SELECT);
    wire logic wr_int = req.wr_en
                        && (req.addr == `OFS_INTERNAL_PLL_CLOCK_SELECT);
    wire logic wr_ref = req.wr_en && (req.addr == `OFS_PLL_REFERENCE_SELECT);
    wire logic wr_oen = req.wr_en && (req.addr == `OFS_CLOCK_OUTPUT_ENABLE);

    // [R12] reserved bits masked on write
    assign conv_sel_next = wr_conv
        ? (req.wr_data & `MASK_CONVERTER_CLOCK_SELECT) : conv_sel_reg;
    assign int_sel_next = wr_int
        ? (req.wr_data & `MASK_INTERNAL_PLL_CLOCK_SELECT) : int_sel_reg;
    assign ref_sel_next = wr_ref
        ? (req.wr_data & `MASK_PLL_REFERENCE_SELECT) : ref_sel_reg;
    assign out_en_next = wr_oen
        ? (req.wr_data & `MASK_CLOCK_OUTPUT_ENABLE) : out_en_reg;

    assign rd_data_next =
        (req.addr == `OFS_CONVERTER_CLOCK_SELECT) ? conv_sel_reg :
        (req.addr == `OFS_INTERNAL_PLL_CLOCK_SELECT) ? int_sel_reg :
        (req.addr == `OFS_PLL_REFERENCE_SELECT) ? ref_sel_reg :
        (req.addr == `OFS_CLOCK_OUTPUT_ENABLE) ? out_en_reg : 8'h00;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            conv_sel_reg <= `RST_CONVERTER_CLOCK_SELECT;
            int_sel_reg <= `RST_INTERNAL_PLL_CLOCK_SELECT;
            ref_sel_reg <= `RST_PLL_REFERENCE_SELECT;
            out_en_reg <= `RST_CLOCK_OUTPUT_ENABLE;
            reg_rd_data <= 8'h00;
        end else begin
            conv_sel_reg <= conv_sel_next;
            int_sel_reg <= int_sel_next;
            ref_sel_reg <= ref_sel_next;
            out_en_reg <= out_en_next;
            if (req.rd_en) begin
                reg_rd_data <= rd_data_next;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            first_pll_reference <= 1'b0;
            second_pll_reference <= 1'b0;
            first_pll_rate_valid <= 1'b0;
            first_pll_rate_code <= `RATE_48K;
            receiver_power_down <= 1'b0;
            receiver_input_level_mode <= 1'b0;
            system_clock_out_a_enable <= 1'b0;
            system_clock_out_b_enable <= 1'b0;
            system_clock_out_c_enable <= 1'b0;
        end else begin
            // [R7] first PLL reference
            first_pll_reference <= ref_sel_reg[`POS_PLL1_REF]
                ? mclk_lvl : xtal_lvl;
            // [R6] second PLL reference
            second_pll_reference <= ref_sel_reg[`POS_PLL2_REF]
                ? mclk_lvl : xtal_lvl;
            // [R11] rate field decode
            first_pll_rate_valid <= rate_ok;
            first_pll_rate_code <= first_pll_rate_select;
            // [R8] receiver power-down
            receiver_power_down <= out_en_reg[`POS_RX_POWER_DOWN];
            // [R9] receiver input level
            receiver_input_level_mode <= out_en_reg[`POS_RX_LEVEL_MODE];
            // [R10] active-low output enables
            system_clock_out_a_enable <= ~out_en_reg[`POS_SYSCLK_A_DIS];
            system_clock_out_b_enable <= ~out_en_reg[`POS_SYSCLK_B_DIS];
            system_clock_out_c_enable <= ~out_en_reg[`POS_SYSCLK_C_DIS];
        end
    end

endmodule : audio_codec_clock_selection

// ### hdl/clock_select_cfg.svh
// offsets, field positions, reset values and codes of the clock selector
// Function
// [R1] The DAC clock select picks crystal, master clock, internal PLL clock A or B, receiver 512 fs or 256 fs, with 110 and 111 falling back to crystal.
// [R2] The ADC clock select uses the same eight-code mapping as the DAC select.
// [R3] The second internal clock select picks crystal, master clock, internal PLL clock A or B for codes 00 to 11.
// [R4] The first internal clock select picks crystal, master clock, internal PLL clock A or B for codes 00 to 11.
// [R5] Internal PLL clock B is the second PLL rate, its half, the alternate rate or its half; clock A is the first PLL rate or its half.
// [R6] Bit 7 of the reference register feeds the second PLL from crystal when 0 and master clock when 1.
// [R7] Bit 6 of the reference register feeds the first PLL from crystal when 0 and master clock when 1.
// [R8] Bit 5 of the output enable register set to 1 powers down the receiver.
// [R9] Bit 4 selects low-amplitude 200 mV receiver input when 0 and standard levels when 1.
// [R10] Bits 2, 1, 0 disable system clock outputs a, b, c when 1 and enable them when 0.
// [R11] The first PLL rate field gives 48 kHz for 00, 32 kHz for 10, 44.1 kHz for 11, 01 reserved.
// [R12] Reserved bits read as zero and ignore writes, and source changes reach converter clocks glitch-free.
`ifndef CLOCK_SELECT_CFG_SVH
`define CLOCK_SELECT_CFG_SVH

`define OFS_CONVERTER_CLOCK_SELECT 7'h76
`define OFS_INTERNAL_PLL_CLOCK_SELECT 7'h77
`define OFS_PLL_REFERENCE_SELECT 7'h78
`define OFS_CLOCK_OUTPUT_ENABLE 7'h7A

`define RST_CONVERTER_CLOCK_SELECT 8'h00
`define RST_INTERNAL_PLL_CLOCK_SELECT 8'h00
`define RST_PLL_REFERENCE_SELECT 8'h00
`define RST_CLOCK_OUTPUT_ENABLE 8'h00

`define MASK_CONVERTER_CLOCK_SELECT 8'hFF
`define MASK_INTERNAL_PLL_CLOCK_SELECT 8'h1F
`define MASK_PLL_REFERENCE_SELECT 8'hC0
`define MASK_CLOCK_OUTPUT_ENABLE 8'h37

`define POS_DAC_SEL_HI 7
`define POS_DAC_SEL_LO 5
`define POS_ADC_SEL_HI 4
`define POS_ADC_SEL_LO 2
`define POS_SECOND_INTERNAL_CLOCK_SELECT_SEL_HI 1
`define POS_SECOND_INTERNAL_CLOCK_SELECT_SEL_LO 0
`define POS_FIRST_INTERNAL_CLOCK_SELECT_SEL_HI 4
`define POS_FIRST_INTERNAL_CLOCK_SELECT_SEL_LO 3
`define POS_PLL2_TAP_HI 2
`define POS_PLL2_TAP_LO 1
`define POS_PLL1_TAP 0
`define POS_PLL2_REF 7
`define POS_PLL1_REF 6
`define POS_RX_POWER_DOWN 5
`define POS_RX_LEVEL_MODE 4
`define POS_SYSCLK_A_DIS 2
`define POS_SYSCLK_B_DIS 1
`define POS_SYSCLK_C_DIS 0

`define SRC_XTAL 3'h0
`define SRC_MCLK 3'h1
`define SRC_PLL_A 3'h2
`define SRC_PLL_B 3'h3
`define SRC_RX_512 3'h4
`define SRC_RX_256 3'h5

`define RATE_48K 2'h0
`define RATE_RESERVED 2'h1
`define RATE_32K 2'h2
`define RATE_44K1 2'h3

`endif

// ### hdl/clock_select_pkg.sv
// types shared by the clock selector
package clock_select_pkg;

    typedef struct packed {
        logic [6:0] addr;
        logic wr_en;
        logic rd_en;
        logic [7:0] wr_data;
    } reg_req_t;

    typedef struct packed {
        logic rx_256;
        logic rx_512;
        logic pll_b;
        logic pll_a;
        logic mclk;
        logic xtal;
    } clock_sources_t;

    typedef enum logic [1:0] {
        SW_RUN,
        SW_DRAIN,
        SW_ARM
    } switch_state_t;

endpackage : clock_select_pkg

// ### tb/clock_select_monitor.sv
// port assertions for the clock selector
`timescale 1ns/100ps
module clock_select_monitor
    import clock_select_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register access
    input wire logic [6:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic [7:0] reg_rd_data,
    // rate decode
    input wire logic [1:0] first_pll_rate_select,
    input wire logic first_pll_rate_valid,
    input wire logic [1:0] first_pll_rate_code,
    // receiver and output control
    input wire logic receiver_power_down,
    input wire logic receiver_input_level_mode,
    input wire logic system_clock_out_a_enable,
    input wire logic system_clock_out_b_enable,
    input wire logic system_clock_out_c_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic mapped = reg_addr inside {7'h76, 7'h77, 7'h78, 7'h7A};
    wire logic [7:0] resv_mask = reg_addr == 7'h77 ? 8'hE0 :
        reg_addr == 7'h78 ? 8'h3F : reg_addr == 7'h7A ? 8'hC8 : 8'h00;
    sequence oe_write;
        reg_wr_en && reg_addr == 7'h7A;
    endsequence
    sequence oe_readback;
        oe_write ##2 (reg_rd_en && !reg_wr_en && reg_addr == 7'h7A);
    endsequence
    unmapped_read_zero_a: assert property (
        reg_rd_en && !mapped |=> reg_rd_data == 8'h00)
        else $error("unmapped read not zero");
    reserved_bits_zero_a: assert property (
        reg_rd_en |=> (reg_rd_data & $past(resv_mask)) == 8'h00)
        else $error("reserved bit read as one");
    oe_readback_a: assert property (
        oe_readback |=> reg_rd_data == ($past(reg_wr_data, 3) & 8'h37))
        else $error("output enable readback wrong");
    read_data_hold_a: assert property (
        !reg_rd_en |=> $stable(reg_rd_data))
        else $error("read data moved without read");
    power_down_follow_a: assert property (
        oe_write |-> ##2 receiver_power_down == $past(reg_wr_data[5], 2))
        else $error("receiver power down wrong");
    level_mode_follow_a: assert property (
        oe_write |-> ##2
        receiver_input_level_mode == $past(reg_wr_data[4], 2))
        else $error("receiver level mode wrong");
    clock_enables_follow_a: assert property (
        oe_write |-> ##2 {system_clock_out_a_enable,
        system_clock_out_b_enable, system_clock_out_c_enable}
        == ~$past(reg_wr_data[2:0], 2))
        else $error("system clock enables wrong");
    rate_code_copy_a: assert property (
        rst_n |=> first_pll_rate_code == $past(first_pll_rate_select))
        else $error("rate code not copied");
    rate_valid_flag_a: assert property (
        rst_n |=> first_pll_rate_valid == ($past(first_pll_rate_select)
        != 2'h1))
        else $error("rate valid flag wrong");
endmodule : clock_select_monitor

bind audio_codec_clock_selection clock_select_monitor u_clock_select_monitor (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .first_pll_rate_select(first_pll_rate_select),
    .first_pll_rate_valid(first_pll_rate_valid),
    .first_pll_rate_code(first_pll_rate_code),
    .receiver_power_down(receiver_power_down),
    .receiver_input_level_mode(receiver_input_level_mode),
    .system_clock_out_a_enable(system_clock_out_a_enable),
    .system_clock_out_b_enable(system_clock_out_b_enable),
    .system_clock_out_c_enable(system_clock_out_c_enable));

// ### tb/test_audio_codec_clock_selection.sv
// self-checking bench for the clock selector
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
    err_count++; $display("Error %s exp %0h got %0h", n, e, g); end end
module test_audio_codec_clock_selection
    import clock_select_pkg::*;
;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0;
    logic [6:0] addr = 7'h00, src = 7'h00;
    logic [7:0] wdata = 8'h00, rdata, v;
    logic [1:0] rate = 2'h0, rcode;
    logic dac, adc, ic1, ic2, ref1, ref2, rval, pd, lvl, ea, eb, ec;
    int err_count = 0, checked = 0, cycles = 0, rise_a = 0, rise_b = 0;
    int model [4] = '{0, 0, 0, 0};
    int mask [4] = '{8'hFF, 8'h1F, 8'hC0, 8'h37};
    always #12.5 clk = ~clk;
    always @(posedge ic1) rise_a++;
    always @(posedge ic2) rise_b++;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            end_of_test();
        end
    end
    audio_codec_clock_selection u_audio_codec_clock_selection (
        .clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wr_en(wr),
        .reg_rd_en(rd), .reg_wr_data(wdata), .reg_rd_data(rdata),
        .crystal_clock_input(src[0]), .external_master_clock_input(src[1]),
        .first_pll_rate_output(src[2]), .second_pll_rate_output(src[3]),
        .second_pll_alt_rate_output(src[6]), .receiver_clock_512fs(src[4]),
        .receiver_clock_256fs(src[5]), .first_pll_rate_select(rate),
        .dac_clock(dac), .adc_clock(adc), .first_internal_clock(ic1),
        .second_internal_clock(ic2), .first_pll_reference(ref1),
        .second_pll_reference(ref2), .first_pll_rate_valid(rval),
        .first_pll_rate_code(rcode), .receiver_power_down(pd),
        .receiver_input_level_mode(lvl), .system_clock_out_a_enable(ea),
        .system_clock_out_b_enable(eb), .system_clock_out_c_enable(ec));
    function automatic int slot(logic [6:0] a);
        return a == 7'h7A ? 3 : (a >= 7'h76 && a <= 7'h78) ? a - 7'h76 : -1;
    endfunction : slot
    task automatic wreg(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk) addr <= a;
        wdata <= d;
        wr <= 1'b1;
        if (slot(a) >= 0) model[slot(a)] = d & mask[slot(a)];
        @(posedge clk) wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [6:0] a);
        @(posedge clk) addr <= a;
        rd <= 1'b1;
        @(posedge clk) rd <= 1'b0;
        #1 `CHK("rd", slot(a) < 0 ? 0 : model[slot(a)], rdata)
    endtask : rreg
    task automatic settle(input logic [6:0] s);
        @(posedge clk) src <= s;
        repeat (12) @(posedge clk);
        #1;
    endtask : settle
    task automatic check(input int c, input int s, input bit h);
        int m = c < 6 ? c : 0;
        int n = (7 - c) < 6 ? 7 - c : 0;
        `CHK("dac", bit'((m == s) == h), dac)
        `CHK("adc", bit'((n == s) == h), adc)
        `CHK("second_internal_clock_select", bit'(((c & 3) == s) == h), ic2)
        `CHK("first_internal_clock_select", bit'(((~c & 3) == s) == h), ic1)
    endtask : check
    task end_of_test;
        if (err_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    initial begin
        void'($urandom(14729));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 'h75; a <= 'h7B; a++) rreg(7'(a));
        for (int i = 0; i < 16; i++) begin
            v = 8'($urandom);
            wreg(7'h75 + 7'($urandom_range(6)), v);
            rreg(addr);
        end
        for (int i = 0; i < 8; i++) begin
            wreg(7'h7A, {8'($urandom)} | 8'(i));
            rreg(7'h7A);
            repeat (2) @(posedge clk);
            #1 `CHK("pd", model[3][5], pd)
            `CHK("lvl", model[3][4], lvl)
            `CHK("en", ~model[3][2:0], {ea, eb, ec})
        end
        for (int r = 0; r < 8; r++) begin
            @(posedge clk) rate <= r < 4 ? 2'(r) : 2'($urandom);
            repeat (2) @(posedge clk);
            #1 `CHK("rcode", rate, rcode)
            `CHK("rval", rate != 2'h1, rval)
        end
        @(posedge clk) rate <= 2'h0;
        for (int c = 0; c < 8; c++) begin
            settle(7'h00);
            wreg(7'h76, {3'(c), 3'(7 - c), 2'(c)});
            wreg(7'h77, {3'h0, ~2'(c), 3'h0});
            for (int s = 0; s < 7; s++) begin
                settle(7'(1 << s));
                check(c, s, 1'b1);
                settle(~7'(1 << s));
                check(c, s, 1'b0);
            end
        end
        wreg(7'h76, 8'h03);
        for (int t = 0; t < 4; t++) begin
            @(posedge clk) rate <= t == 3 ? 2'h1 : 2'h3;
            wreg(7'h77, {3'h0, 2'h2, 2'(t), t[0]});
            settle(7'h00);
            rise_a = 0;
            rise_b = 0;
            repeat (8) begin
                settle(7'h0C);
                settle(7'h00);
            end
            `CHK("tap2", t[1] ? 0 : t[0] ? 4 : 8, rise_b)
            `CHK("tap1", t == 3 ? 0 : t[0] ? 4 : 8, rise_a)
        end
        for (int i = 0; i < 4; i++) begin
            wreg(7'h78, {2'(i), 6'h00});
            settle(7'h01);
            `CHK("ref1x", !i[0], ref1)
            `CHK("ref2x", !i[1], ref2)
            settle(7'h02);
            `CHK("ref1m", i[0], ref1)
            `CHK("ref2m", i[1], ref2)
        end
        @(posedge clk) rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        model = '{0, 0, 0, 0};
        for (int a = 'h76; a <= 'h7A; a++) rreg(7'(a));
        `CHK("pd_rst", 1'b0, pd)
        `CHK("en_rst", 3'h7, {ea, eb, ec})
        end_of_test();
    end
endmodule : test_audio_codec_clock_selection
